// >>> core/pcct_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - pulse interrupt drives line low then high, each exactly four clocks.
// - each phase length in internal clocks is prescale times multiplier plus one.
// - phase values come from the timer set chosen for the socket window.
// - counters advance on an internal clock of twice the bus clock period.
// - attribute, enables (except I/O high enable), address and write data stable for setup count before strobe.
// - strobe held for command count, then address and data kept for recovery count.
// - timer set 0 resets to setup 01h, command 05h, recovery 00h.
// - setup registers at 3Ah and 3Dh, command and recovery at following indexes.
// - strobe extended during wait and held three internal clocks after release.
// - read data sampled two internal clocks before read strobe ends, at its end for command counts under three with no wait.
// - 16-bit width flag honoured only within three internal clocks of cycle start.
// - high card enable follows observed 16-bit flag by one internal clock, except on an 8-bit host.
// - 8-bit host uses same counts and same data sampling point.
// - word I/O address and write data held for recovery count after strobe.
module pcct_core (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_req,
  input  wire logic        i_req_io,
  input  wire logic        i_req_write,
  input  wire logic        i_req_word,
  input  wire logic        i_req_attr,
  input  wire logic        i_req_tset,
  input  wire logic [25:0] i_req_addr,
  input  wire logic [15:0] i_req_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic      [15:0] o_rd_data,
  output logic      [25:0] o_card_addr,
  output logic      [15:0] o_card_dout,
  output logic             o_card_doe_n,
  input  wire logic [15:0] i_card_din,
  output logic             o_reg_n,
  output logic             o_ce1_n,
  output logic             o_ce2_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic             o_iord_n,
  output logic             o_iowr_n,
  input  wire logic        i_wait_n,
  input  wire logic        i_iois16_n,
  output logic             o_irq,
  output logic             o_sysirq_out,
  output logic             o_sysirq_oe_n
);

  typedef struct packed {
    logic [7:0]           setup0;
    logic [7:0]           cmd0;
    logic [7:0]           rec0;
    logic [7:0]           setup1;
    logic [7:0]           cmd1;
    logic [7:0]           rec1;
    logic [7:0]           status;
    logic [7:0]           mask;
    logic [7:0]           ctrl;
    logic [7:0]           rdata;
    logic                 div;
    pcct_pkg::pcct_state_t state;
    logic [9:0]           cnt;
    logic                 io;
    logic                 write;
    logic                 word;
    logic                 tset;
    logic                 wait_s;
    logic                 saw_wait;
    logic                 sampled;
    logic [1:0]           tcnt;
    logic                 wide;
    logic                 busy;
    logic                 done;
    logic [15:0]          rd_data;
    logic [25:0]          addr;
    logic [15:0]          dout;
    logic                 doe_n;
    logic                 reg_n;
    logic                 ce1_n;
    logic                 ce2_n;
    logic                 oe_n;
    logic                 we_n;
    logic                 iord_n;
    logic                 iowr_n;
    logic                 irq;
    logic [3:0]           pcnt;
    logic                 pout;
    logic                 poe_n;
  } pcct_regs_t;

  pcct_regs_t s_r;
  pcct_regs_t s_nxt;

  function automatic logic [9:0] phase_count(input logic [7:0] r);
    logic [9:0] pres;
    logic [9:0] mult;
    mult = {4'h0, r[pcct_pkg::MULT_LSB +: pcct_pkg::MULT_W]};
    case (r[pcct_pkg::PRES_LSB +: pcct_pkg::PRES_W])
      2'h0:    pres = pcct_pkg::PRES_SEL0;
      2'h1:    pres = pcct_pkg::PRES_SEL1;
      2'h2:    pres = pcct_pkg::PRES_SEL2;
      default: pres = pcct_pkg::PRES_SEL3;
    endcase
    phase_count = 10'(pres * mult) + 10'h001;
  endfunction : phase_count

  always_comb begin
    logic       tick;
    logic [7:0] set_setup;
    logic [7:0] set_cmd;
    logic [7:0] set_rec;
    logic       rd_cyc;
    tick   = 1'b0;
    rd_cyc = 1'b0;
    s_nxt  = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.done  = 1'b0;
    // internal clock: one enable every second bus clock
    s_nxt.div = ~s_r.div;
    tick      = s_r.div;
    // per-window timer set, frozen for the whole cycle
    set_setup = s_r.tset ? s_r.setup1 : s_r.setup0;
    set_cmd   = s_r.tset ? s_r.cmd1   : s_r.cmd0;
    set_rec   = s_r.tset ? s_r.rec1   : s_r.rec0;
    rd_cyc    = ~s_r.write;

    if (i_wr) begin
      case (i_addr)
        pcct_pkg::OFF_SETUP0: s_nxt.setup0 = i_wdata;
        pcct_pkg::OFF_CMD0:   s_nxt.cmd0   = i_wdata;
        pcct_pkg::OFF_REC0:   s_nxt.rec0   = i_wdata;
        pcct_pkg::OFF_SETUP1: s_nxt.setup1 = i_wdata;
        pcct_pkg::OFF_CMD1:   s_nxt.cmd1   = i_wdata;
        pcct_pkg::OFF_REC1:   s_nxt.rec1   = i_wdata;
        pcct_pkg::OFF_MASK:   s_nxt.mask   = i_wdata;
        pcct_pkg::OFF_CTRL:   s_nxt.ctrl   = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        pcct_pkg::OFF_SETUP0: s_nxt.rdata = s_r.setup0;
        pcct_pkg::OFF_CMD0:   s_nxt.rdata = s_r.cmd0;
        pcct_pkg::OFF_REC0:   s_nxt.rdata = s_r.rec0;
        pcct_pkg::OFF_SETUP1: s_nxt.rdata = s_r.setup1;
        pcct_pkg::OFF_CMD1:   s_nxt.rdata = s_r.cmd1;
        pcct_pkg::OFF_REC1:   s_nxt.rdata = s_r.rec1;
        pcct_pkg::OFF_MASK:   s_nxt.rdata = s_r.mask;
        pcct_pkg::OFF_CTRL:   s_nxt.rdata = s_r.ctrl;
        pcct_pkg::OFF_STATUS: begin
          s_nxt.rdata  = s_r.status;
          s_nxt.status = 8'h00;
        end
        default:              s_nxt.rdata = 8'h00;
      endcase
    end

    // wait is only looked at on internal clock edges
    if (tick) begin
      s_nxt.wait_s = ~i_wait_n;
    end

    // 16-bit flag window, counted in internal clocks from cycle start
    if (s_r.busy && s_r.io && s_r.word && !s_r.wide && tick
        && s_r.tcnt < pcct_pkg::IOIS_WINDOW) begin
      s_nxt.tcnt = s_r.tcnt + 2'h1;
      if (!i_iois16_n) begin
        s_nxt.wide = 1'b1;
      end else if (s_r.tcnt == pcct_pkg::IOIS_WINDOW - 2'h1) begin
        s_nxt.status[pcct_pkg::ST_NARROW] = 1'b1;
      end
    end
    // flag seen last internal clock: raise high enable one internal clock later
    if (s_r.wide && tick && s_r.ce2_n && !s_r.ctrl[pcct_pkg::CTRL_HOST8]
        && s_r.state != pcct_pkg::PCCT_REC) begin
      s_nxt.ce2_n = 1'b0;
    end

    case (s_r.state)
      pcct_pkg::PCCT_IDLE: begin
        if (i_req) begin
          s_nxt.state    = pcct_pkg::PCCT_SETUP;
          s_nxt.io       = i_req_io;
          s_nxt.write    = i_req_write;
          s_nxt.word     = i_req_word;
          s_nxt.tset     = i_req_tset;
          s_nxt.busy     = 1'b1;
          s_nxt.saw_wait = 1'b0;
          s_nxt.sampled  = 1'b0;
          s_nxt.tcnt     = 2'h0;
          s_nxt.wide     = 1'b0;
          s_nxt.addr     = i_req_addr;
          s_nxt.dout     = i_req_wdata;
          s_nxt.doe_n    = ~i_req_write;
          s_nxt.reg_n    = ~i_req_attr;
          s_nxt.ce1_n    = 1'b0;
          // memory words enable both bytes at once unless on an 8-bit host; I/O words wait for the card
          s_nxt.ce2_n    = ~(i_req_word && !i_req_io
                             && !s_r.ctrl[pcct_pkg::CTRL_HOST8]);
          s_nxt.cnt      = phase_count(i_req_tset ? s_r.setup1 : s_r.setup0);
        end
      end
      pcct_pkg::PCCT_SETUP: begin
        if (tick) begin
          if (s_r.cnt == 10'h001) begin
            s_nxt.state  = pcct_pkg::PCCT_CMD;
            s_nxt.cnt    = phase_count(set_cmd);
            s_nxt.oe_n   = ~(rd_cyc && !s_r.io);
            s_nxt.we_n   = ~(s_r.write && !s_r.io);
            s_nxt.iord_n = ~(rd_cyc && s_r.io);
            s_nxt.iowr_n = ~(s_r.write && s_r.io);
          end else begin
            s_nxt.cnt = s_r.cnt - 10'h001;
          end
        end
      end
      pcct_pkg::PCCT_CMD: begin
        if (tick) begin
          if (s_r.wait_s) begin
            s_nxt.saw_wait = 1'b1;
          end
          // nominal sampling point, only valid when no wait stretched it
          if (s_r.cnt == pcct_pkg::DATA_LEAD + 10'h001 && !s_r.wait_s
              && !s_r.saw_wait && rd_cyc) begin
            s_nxt.rd_data = i_card_din;
            s_nxt.sampled = 1'b1;
          end
          if (s_r.cnt != 10'h001) begin
            s_nxt.cnt = s_r.cnt - 10'h001;
          end else if (s_r.wait_s) begin
            s_nxt.cnt = s_r.cnt;
          end else if (s_r.saw_wait) begin
            s_nxt.state   = pcct_pkg::PCCT_HOLD;
            s_nxt.cnt     = pcct_pkg::WAIT_HOLD + 10'h001;
            s_nxt.sampled = 1'b0;
          end else begin
            if (!s_r.sampled && rd_cyc) begin
              // short command counts leave no earlier point
              s_nxt.rd_data = i_card_din;
            end
            s_nxt.state  = pcct_pkg::PCCT_REC;
            s_nxt.cnt    = phase_count(set_rec);
            s_nxt.oe_n   = 1'b1;
            s_nxt.we_n   = 1'b1;
            s_nxt.iord_n = 1'b1;
            s_nxt.iowr_n = 1'b1;
          end
        end
      end
      pcct_pkg::PCCT_HOLD: begin
        if (tick) begin
          // one internal clock after release the card data is valid
          if (s_r.cnt == pcct_pkg::DATA_LEAD + 10'h001 && rd_cyc) begin
            s_nxt.rd_data = i_card_din;
          end
          if (s_r.cnt == 10'h001) begin
            s_nxt.state  = pcct_pkg::PCCT_REC;
            s_nxt.cnt    = phase_count(set_rec);
            s_nxt.oe_n   = 1'b1;
            s_nxt.we_n   = 1'b1;
            s_nxt.iord_n = 1'b1;
            s_nxt.iowr_n = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 10'h001;
          end
        end
      end
      pcct_pkg::PCCT_REC: begin
        if (tick) begin
          if (s_r.cnt == 10'h001) begin
            s_nxt.state = pcct_pkg::PCCT_IDLE;
            s_nxt.busy  = 1'b0;
            s_nxt.done  = 1'b1;
            s_nxt.doe_n = 1'b1;
            s_nxt.ce1_n = 1'b1;
            s_nxt.ce2_n = 1'b1;
            s_nxt.reg_n = 1'b1;
            s_nxt.status[pcct_pkg::ST_DONE] = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 10'h001;
          end
        end
      end
      default: begin
        s_nxt.state = pcct_pkg::PCCT_IDLE;
      end
    endcase

    // events after the read clear, so a same-cycle event survives
    s_nxt.irq = |(s_nxt.status & s_r.mask);

    // system line: level follows irq, pulse mode sends low-high once per rise
    if (s_r.pcnt != 4'h0) begin
      s_nxt.pcnt = s_r.pcnt - 4'h1;
      s_nxt.pout = (s_r.pcnt > pcct_pkg::IRQ_PULSE + 4'h1) ? 1'b0 : 1'b1;
      s_nxt.poe_n = (s_r.pcnt == 4'h1);
    end else if (s_r.ctrl[pcct_pkg::CTRL_PULSE]) begin
      s_nxt.poe_n = 1'b1;
      s_nxt.pout  = 1'b1;
      if (s_nxt.irq && !s_r.irq) begin
        s_nxt.pcnt  = 4'(2 * pcct_pkg::IRQ_PULSE);
        s_nxt.pout  = 1'b0;
        s_nxt.poe_n = 1'b0;
      end
    end else begin
      s_nxt.pout  = s_nxt.irq;
      s_nxt.poe_n = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r          <= '0;
      s_r.setup0   <= pcct_pkg::RST_SETUP0;
      s_r.cmd0     <= pcct_pkg::RST_CMD0;
      s_r.rec0     <= pcct_pkg::RST_REC0;
      s_r.setup1   <= pcct_pkg::RST_SET1;
      s_r.cmd1     <= pcct_pkg::RST_SET1;
      s_r.rec1     <= pcct_pkg::RST_SET1;
      s_r.mask     <= pcct_pkg::RST_MASK;
      s_r.ctrl     <= pcct_pkg::RST_CTRL;
      s_r.state    <= pcct_pkg::PCCT_IDLE;
      s_r.doe_n    <= 1'b1;
      s_r.reg_n    <= 1'b1;
      s_r.ce1_n    <= 1'b1;
      s_r.ce2_n    <= 1'b1;
      s_r.oe_n     <= 1'b1;
      s_r.we_n     <= 1'b1;
      s_r.iord_n   <= 1'b1;
      s_r.iowr_n   <= 1'b1;
      s_r.pout     <= 1'b1;
      s_r.poe_n    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata       = s_r.rdata;
  assign o_busy        = s_r.busy;
  assign o_done        = s_r.done;
  assign o_rd_data     = s_r.rd_data;
  assign o_card_addr   = s_r.addr;
  assign o_card_dout   = s_r.dout;
  assign o_card_doe_n  = s_r.doe_n;
  assign o_reg_n       = s_r.reg_n;
  assign o_ce1_n       = s_r.ce1_n;
  assign o_ce2_n       = s_r.ce2_n;
  assign o_oe_n        = s_r.oe_n;
  assign o_we_n        = s_r.we_n;
  assign o_iord_n      = s_r.iord_n;
  assign o_iowr_n      = s_r.iowr_n;
  assign o_irq         = s_r.irq;
  assign o_sysirq_out  = s_r.pout;
  assign o_sysirq_oe_n = s_r.poe_n;

endmodule : pcct_core

// >>> shared/pcct_pkg.sv
package pcct_pkg;
  // register indexes
  localparam logic [7:0] OFF_SETUP0   = 8'h3a;
  localparam logic [7:0] OFF_CMD0     = 8'h3b;
  localparam logic [7:0] OFF_REC0     = 8'h3c;
  localparam logic [7:0] OFF_SETUP1   = 8'h3d;
  localparam logic [7:0] OFF_CMD1     = 8'h3e;
  localparam logic [7:0] OFF_REC1     = 8'h3f;
  localparam logic [7:0] OFF_STATUS   = 8'h40;
  localparam logic [7:0] OFF_MASK     = 8'h41;
  localparam logic [7:0] OFF_CTRL     = 8'h42;
  // reset values
  localparam logic [7:0] RST_SETUP0   = 8'h01;
  localparam logic [7:0] RST_CMD0     = 8'h05;
  localparam logic [7:0] RST_REC0     = 8'h00;
  localparam logic [7:0] RST_SET1     = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_MASK     = 8'h00;
  // timing register fields
  localparam int         MULT_LSB     = 0;
  localparam int         MULT_W       = 6;
  localparam int         PRES_LSB     = 6;
  localparam int         PRES_W       = 2;
  localparam logic [9:0] PRES_SEL0    = 10'h001;
  localparam logic [9:0] PRES_SEL1    = 10'h002;
  localparam logic [9:0] PRES_SEL2    = 10'h004;
  localparam logic [9:0] PRES_SEL3    = 10'h008;
  localparam int         CNT_W        = 10;
  // status and control bit positions
  localparam int         ST_DONE      = 0;
  localparam int         ST_NARROW    = 1;
  localparam int         CTRL_PULSE   = 0;
  localparam int         CTRL_HOST8   = 1;
  // timing
  localparam int         CLK_NS       = 25;
  localparam int         TCP_NS       = 2 * CLK_NS;
  localparam int         TCP_CLKS     = TCP_NS / CLK_NS;
  localparam logic [3:0] IRQ_PULSE    = 4'h4;
  localparam logic [9:0] WAIT_HOLD    = 10'h002;
  localparam logic [9:0] DATA_LEAD    = 10'h002;
  localparam logic [1:0] IOIS_WINDOW  = 2'h3;

  typedef enum logic [4:0] {
    PCCT_IDLE  = 5'b00001,
    PCCT_SETUP = 5'b00010,
    PCCT_CMD   = 5'b00100,
    PCCT_HOLD  = 5'b01000,
    PCCT_REC   = 5'b10000
  } pcct_state_t;
endpackage : pcct_pkg

// >>> testbench/pcct_card_model.sv
`timescale 1ns/1ps
module pcct_card_model (
  input  wire logic        i_clk,
  input  wire logic        i_oe_n,
  input  wire logic        i_iord_n,
  input  wire logic        i_ce1_n,
  input  wire logic [25:0] i_addr,
  input  wire logic [7:0]  i_wait_len,
  input  wire logic        i_is16,
  output logic      [15:0] o_din,
  output logic             o_wait_n,
  output logic             o_iois16_n
);
  logic [7:0]  cnt_r  = 8'h00;
  logic        wait_r = 1'b1;
  logic [15:0] din_r  = 16'h0000;
  logic        rd;
  assign rd = !i_oe_n || !i_iord_n;
  assign o_iois16_n = !(i_is16 && !i_ce1_n);
  assign o_wait_n   = wait_r;
  assign o_din      = din_r;
  always @(posedge i_clk) begin
    cnt_r <= rd ? cnt_r + {7'h00, cnt_r != 8'hff} : 8'h00;
    wait_r <= !(rd && cnt_r < i_wait_len);
    // garbage while idle or waiting, so a late sample shows
    if (rd && wait_r) begin
      din_r <= i_addr[15:0] ^ 16'h5a5a;
    end else begin
      din_r <= ~din_r;
    end
  end
endmodule : pcct_card_model

// >>> testbench/pcct_core_bench.sv
`timescale 1ns/1ps
module pcct_core_bench;
  logic        i_clk, i_rst, i_wr, i_rd, i_req, i_req_io, i_req_write, i_req_word;
  logic        i_req_attr, i_req_tset, o_busy, o_done, o_card_doe_n, o_reg_n, o_ce1_n;
  logic        o_ce2_n, o_oe_n, o_we_n, o_iord_n, o_iowr_n, i_wait_n, i_iois16_n, is16;
  logic        o_irq, o_sysirq_out, o_sysirq_oe_n;
  logic [7:0]  i_addr, i_wdata, o_rdata, wait_len;
  logic [25:0] i_req_addr, o_card_addr;
  logic [15:0] i_req_wdata, o_rd_data, o_card_dout, i_card_din;
  int          bad_count, comparisons, su, cw, rc, ce2_lo, dl, rg, wl;
  pcct_core pcct_core_inst (.*);
  pcct_card_model pcct_card_model_inst (.i_clk(i_clk), .i_oe_n(o_oe_n), .i_iord_n(o_iord_n),
    .i_ce1_n(o_ce1_n), .i_addr(o_card_addr), .i_wait_len(wait_len), .i_is16(is16),
    .o_din(i_card_din), .o_wait_n(i_wait_n), .o_iois16_n(i_iois16_n));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  function automatic int cnt(input logic [7:0] r);
    return (1 << r[7:6]) * int'(r[5:0]) + 1;
  endfunction : cnt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata === e, "register read");
  endtask : rd
  // phases counted in bus clocks at the card pins
  task automatic cyc(input logic io, input logic w, input logic wd, input logic ts,
                     input logic [25:0] a);
    int   n;
    logic st;
    @(posedge i_clk);
    i_req <= 1'b1;
    {i_req_io, i_req_write, i_req_word, i_req_tset, i_req_attr} <= {io, w, wd, ts, ts};
    i_req_addr <= a;
    i_req_wdata <= ~a[15:0];
    @(posedge i_clk);
    i_req <= 1'b0;
    su = 0;
    cw = 0;
    rc = 0;
    ce2_lo = 0;
    dl = 0;
    rg = 0;
    wl = 0;
    for (n = 0; n < 400; n++) begin
      #1;
      st = o_oe_n & o_we_n & o_iord_n & o_iowr_n;
      if (o_ce1_n === 1'b0 && st === 1'b1 && cw == 0) su++;
      if (o_ce1_n === 1'b0 && st === 1'b1 && cw > 0) rc++;
      if (st === 1'b0) cw++;
      if (o_ce2_n === 1'b0) ce2_lo++;
      if (o_card_doe_n === 1'b0) dl++;
      if (o_reg_n === 1'b0) rg++;
      if (o_we_n === 1'b0) wl++;
      if (o_done === 1'b1) break;
      @(posedge i_clk);
    end
    if (n == 400) begin
      chk(1'b0, "card cycle never done");
      end_sim;
    end
  endtask : cyc
  task automatic ph(input int s, input int c, input int r);
    chk(su >= 2 * s - 1 && su <= 2 * s + 1, "setup length");
    chk(cw == 2 * c, "command length");
    chk(rc == 2 * r, "recovery length");
  endtask : ph
  task automatic t_regs;
    logic [7:0] v [3] = '{8'h42, 8'h83, 8'hc1};
    rd(8'h3a, 8'h01);
    rd(8'h3b, 8'h05);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h3d + 8'(i), v[i]);
      rd(8'h3d + 8'(i), v[i]);
    end
    wr(8'h55, 8'ha5);
    rd(8'h55, 8'h00);
    rd(8'h3a, 8'h01);
  endtask : t_regs
  task automatic t_mem;
    cyc(1'b0, 1'b0, 1'b1, 1'b0, 26'h0001234);
    ph(cnt(8'h01), cnt(8'h05), cnt(8'h00));
    chk(o_rd_data === (16'h1234 ^ 16'h5a5a), "memory read data");
    chk(ce2_lo > 0, "word memory high enable");
    chk(dl == 0 && rg == 0 && wl == 0, "read drove data or attribute");
    rd(8'h40, 8'h01);
  endtask : t_mem
  task automatic t_set1;
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 26'h2000456);
    ph(cnt(8'h42), cnt(8'h83), cnt(8'hc1));
    chk(ce2_lo == 0, "byte write high enable");
    chk(dl == su + cw + rc, "write data not driven");
    chk(rg == su + cw + rc, "attribute select missing");
    chk(wl == cw, "memory write strobe");
    chk(o_card_dout === ~16'h0456, "write data value");
    rd(8'h40, 8'h01);
  endtask : t_set1
  task automatic t_wait;
    wait_len <= 8'd20;
    cyc(1'b0, 1'b0, 1'b1, 1'b0, 26'h0000777);
    chk(cw >= 24, "strobe not extended");
    chk(o_rd_data === (16'h0777 ^ 16'h5a5a), "read data after wait");
    wait_len <= 8'd0;
    rd(8'h40, 8'h01);
  endtask : t_wait
  task automatic t_io;
    is16 <= 1'b1;
    cyc(1'b1, 1'b0, 1'b1, 1'b0, 26'h0000abc);
    chk(ce2_lo > 0, "high enable missing");
    chk(o_rd_data === (16'h0abc ^ 16'h5a5a), "io read data");
    ph(cnt(8'h01), cnt(8'h05), cnt(8'h00));
    rd(8'h40, 8'h01);
    is16 <= 1'b0;
    cyc(1'b1, 1'b1, 1'b1, 1'b0, 26'h0000def);
    chk(ce2_lo == 0, "high enable without flag");
    rd(8'h40, 8'h03);
    rd(8'h40, 8'h00);
  endtask : t_io
  task automatic t_irq;
    int lo;
    int hi;
    int seen;
    lo = 0;
    hi = 0;
    seen = 0;
    wr(8'h42, 8'h01);
    wr(8'h41, 8'h01);
    rd(8'h41, 8'h01);
    cyc(1'b0, 1'b0, 1'b0, 1'b0, 26'h0000100);
    // the pulse starts in the done cycle itself, so look at it first
    repeat (30) begin
      if (o_irq === 1'b1) seen++;
      if (o_sysirq_oe_n === 1'b0 && o_sysirq_out === 1'b0) lo++;
      if (o_sysirq_oe_n === 1'b0 && o_sysirq_out === 1'b1) hi++;
      @(posedge i_clk);
      #1;
    end
    chk(seen > 0, "interrupt not raised");
    chk(lo == 4 && hi == 4, "pulse length");
    rd(8'h40, 8'h01);
    @(posedge i_clk);
    #1;
    chk(o_irq === 1'b0, "interrupt not cleared");
    wr(8'h41, 8'h00);
    cyc(1'b0, 1'b0, 1'b0, 1'b0, 26'h0000200);
    repeat (4) @(posedge i_clk);
    #1;
    chk(o_irq === 1'b0, "masked interrupt raised");
    rd(8'h40, 8'h01);
  endtask : t_irq
  task automatic t_host8;
    wr(8'h42, 8'h03);
    cyc(1'b0, 1'b0, 1'b1, 1'b0, 26'h0000321);
    chk(ce2_lo == 0, "high enable on 8-bit host");
    chk(cw == 2 * cnt(8'h05), "8-bit host command length");
    rd(8'h40, 8'h01);
  endtask : t_host8
  initial begin
    {i_rst, i_wr, i_rd, i_req, i_req_io, i_req_write, i_req_word} = 7'h40;
    {i_req_attr, i_req_tset, is16} = 3'h0;
    {i_addr, i_wdata, wait_len} = 24'h000000;
    i_req_addr = 26'h0000000;
    i_req_wdata = 16'h0000;
    bad_count = 0;
    comparisons = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs;
    t_mem;
    t_set1;
    t_wait;
    t_io;
    t_irq;
    t_host8;
    end_sim;
  end
endmodule : pcct_core_bench

// >>> testbench/pcct_core_sva.sv
`timescale 1ns/1ps
module pcct_core_sva (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        o_busy,
  input  wire logic        o_done,
  input  wire logic [25:0] o_card_addr,
  input  wire logic        o_ce1_n,
  input  wire logic        o_ce2_n,
  input  wire logic        o_oe_n,
  input  wire logic        o_we_n,
  input  wire logic        o_iord_n,
  input  wire logic        o_iowr_n,
  input  wire logic        i_wait_n,
  input  wire logic        i_iois16_n,
  input  wire logic        o_sysirq_out,
  input  wire logic        o_sysirq_oe_n
);
  logic st_n;
  assign st_n = o_oe_n & o_we_n & o_iord_n & o_iowr_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // level-mode edges right after reset are not pulses
  property p_irq_pulse;
    $fell(o_sysirq_out) && $past(o_sysirq_oe_n) && !$past(i_rst, 2) |->
      !o_sysirq_out [*4] ##1 o_sysirq_out [*4] ##1 o_sysirq_oe_n;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse length wrong");
  property p_setup;
    $fell(st_n) |-> !$past(o_ce1_n, 2) && $stable(o_card_addr);
  endproperty
  a_setup: assert property (p_setup) else $error("strobe without setup");
  property p_addr_hold;
    !o_ce1_n && !$past(o_ce1_n) |-> $stable(o_card_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
  property p_cmd_min;
    $fell(st_n) |-> !st_n [*2];
  endproperty
  a_cmd_min: assert property (p_cmd_min) else $error("strobe too short");
  property p_recovery;
    $rose(o_ce1_n) |-> $past(st_n, 1) && $past(st_n, 2);
  endproperty
  a_recovery: assert property (p_recovery) else $error("no recovery before enable off");
  property p_wait_ext;
    !st_n && !i_wait_n |=> !st_n;
  endproperty
  a_wait_ext: assert property (p_wait_ext) else $error("strobe ended during wait");
  property p_wait_hold;
    $rose(i_wait_n) && !st_n |-> !st_n [*4];
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("strobe ended soon after wait");
  property p_ce2_late;
    $fell(o_ce2_n) && !$past(o_ce1_n) |-> !$past(i_iois16_n, 2);
  endproperty
  a_ce2_late: assert property (p_ce2_late) else $error("high enable before width flag");
  property p_one_strobe;
    !st_n |-> !o_ce1_n && $onehot({o_oe_n, o_we_n, o_iord_n, o_iowr_n} ^ 4'hf);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("bad strobe combination");
  property p_done;
    o_done |-> !o_busy && $past(o_busy) && o_ce1_n ##1 !o_done;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
endmodule : pcct_core_sva
bind pcct_core pcct_core_sva pcct_core_sva_inst (.*);
